// ### pkg/fta_defs.svh
`ifndef FTA_DEFS_SVH
`define FTA_DEFS_SVH
// Contract
// - configure mode reports no alarms whatever the sensor shows.
// - monitor cut view shows cuts remaining, one less per recognised cut.
// - energy above threshold pulses threshold indicator and lowers cuts remaining.
// - first event opens a per-zone window; alarm only if target reached inside.
// - cut alarm lights cut, alarm and affected zone indicators together.
// - a value common to both zones lights both zone indicators.
// - level mode detects nothing and shows peak disturbance of selected zone.
// - entering level mode auto-clears: reading held about two seconds, then 00.
// - clear selects manual clearing; leaving and re-entering level restores auto.
// - cut window 1 to 99 seconds, default 30.
// - climb window from climb time up to 99 seconds, default 20.
// - cut and climb thresholds 1 to 20, default 10.
// - cut count 1 to 10, default 4.
// - climb time 1 second up to climb window, default 2.
// - relays held for relay time on alarm; supervision relay minimum too; default 2.
// - each cut extends open cut window by profile times ten percent; default 02.
// - peak trigger separates intrusion from environment, default 03 meaning 30 percent.
// - ambient compensation added to thresholds in proportion; 10 means full; default 10.
// - common mode 01 compensates only if zones similar; 00 always; default 00.

`define FTA_CLK_NS     4
`define FTA_SEC_NS     1000000000
`define FTA_DECI       10
`define FTA_HOLD_S     2

`define FTA_A_CTRL     12'h000
`define FTA_A_CLEAR    12'h004
`define FTA_A_STATUS   12'h008
`define FTA_A_DISP     12'h00c
`define FTA_A_UNLOCK   12'h010
// zone params at 0x020 (zone 0) and 0x040 (zone 1), functional at 0x060
`define FTA_ZP_N       6
`define FTA_FP_N       5

`define FTA_CWIN_DEF   7'h1e
`define FTA_KWIN_DEF   7'h14
`define FTA_THR_DEF    7'h0a
`define FTA_CCNT_DEF   7'h04
`define FTA_CTIM_DEF   7'h02
`define FTA_RLY_DEF    7'h02
`define FTA_PROF_DEF   7'h02
`define FTA_PEAK_DEF   7'h03
`define FTA_AMB_DEF    7'h0a
`define FTA_CMOD_DEF   7'h00

`define FTA_WIN_MIN    7'h01
`define FTA_WIN_MAX    7'h63
`define FTA_THR_MIN    7'h01
`define FTA_THR_MAX    7'h14
`define FTA_CCNT_MIN   7'h01
`define FTA_CCNT_MAX   7'h0a
`define FTA_CTIM_MIN   7'h01
`define FTA_RLY_MIN    7'h01
`define FTA_RLY_MAX    7'h63
`define FTA_FP_MAX     7'h0a
`define FTA_CMOD_MAX   7'h01
`define FTA_DISP_MAX   8'h63
`endif

// ### pkg/fta_pkg.sv
package fta_pkg;
  typedef enum logic [1:0] {
    FTA_MON = 2'b00,
    FTA_CFG = 2'b01,
    FTA_LVL = 2'b11
  } fta_mode_e;

  typedef struct packed {
    logic monitor;
    logic configure;
    logic level;
    logic zone1;
    logic zone2;
    logic cut;
    logic climb;
    logic window;
    logic threshold;
    logic alarm;
    logic supervision;
  } fta_led_s;
endpackage

// ### core/fta_top.sv
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "fta_defs.svh"
module fta_top import fta_pkg::*; #(
  parameter int          SEC_CYC   = `FTA_SEC_NS / `FTA_CLK_NS,
  parameter logic [7:0]  AMB_TOL   = 8'h10,
  parameter logic [7:0]  THR_SCALE = 8'h08,
  parameter logic [15:0] CIPHER    = 16'h5a5a  // arbitrary value
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [1:0][7:0] sensor_energy,
  input  wire logic [1:0][7:0] ambient_level,
  input  wire logic            supervision_in,
  output logic      [1:0]      alarm_relay,
  output logic                 supervision_relay,
  output fta_led_s             leds,
  output logic      [6:0]      display
);
  localparam int DECI_RAW = SEC_CYC / `FTA_DECI;
  localparam int DECI_CYC = (DECI_RAW < 1) ? 1 : DECI_RAW;
  localparam logic [4:0] HOLD_D = 5'(`FTA_HOLD_S * `FTA_DECI);

  fta_mode_e        mode_q;
  logic             zsel_q;
  logic             ssel_q;
  logic [2:0]       psel_q;
  logic             fview_q;
  logic             unlock_q;
  logic             manual_q;
  logic [6:0]       zp_q [2][`FTA_ZP_N];
  logic [6:0]       fp_q [`FTA_FP_N];
  logic [31:0]      pre_q;
  logic             tick;
  logic [1:0][7:0]  en_s1, en_s2, am_s1, am_s2;
  logic             sup_s1, sup_s2;
  logic             detect, comp_on, similar;
  logic [7:0]       amb_diff;
  logic [1:0]       cut_ev, clb_ev, relay_on, alm_cut, alm_clb, cwin_on, kwin_on;
  logic [6:0]       rem_cut [2];
  logic [6:0]       rem_clb [2];
  logic [7:0]       peak_q;
  logic [4:0]       hold_q;
  logic [9:0]       sup_tmr_q;
  logic             thr_q;
  logic             clr_wr;
  logic             zhit, fhit, chit, ok_wr, acc;
  logic [6:0]       wv;
  logic [31:0]      rdata;
  logic             rerr;
  fta_led_s         led_d;
  logic [6:0]       disp_d;

  function automatic logic [6:0] clampv(input logic [6:0] v, input logic [6:0] lo,
                                        input logic [6:0] hi);
    clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [6:0] zdef(input int k);
    case (k)
      0:       zdef = `FTA_CWIN_DEF;
      1:       zdef = `FTA_KWIN_DEF;
      2, 3:    zdef = `FTA_THR_DEF;
      4:       zdef = `FTA_CCNT_DEF;
      default: zdef = `FTA_CTIM_DEF;
    endcase
  endfunction

  function automatic logic [6:0] fdef(input int k);
    case (k)
      0:       fdef = `FTA_RLY_DEF;
      1:       fdef = `FTA_PROF_DEF;
      2:       fdef = `FTA_PEAK_DEF;
      3:       fdef = `FTA_AMB_DEF;
      default: fdef = `FTA_CMOD_DEF;
    endcase
  endfunction

  // pin inputs pass two flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_s1  <= '0;
      en_s2  <= '0;
      am_s1  <= '0;
      am_s2  <= '0;
      sup_s1 <= 1'b0;
      sup_s2 <= 1'b0;
    end else begin
      en_s1  <= sensor_energy;
      en_s2  <= en_s1;
      am_s1  <= ambient_level;
      am_s2  <= am_s1;
      sup_s1 <= supervision_in;
      sup_s2 <= sup_s1;
    end
  end

  // tenth-of-a-second tick
  assign tick = (pre_q == 32'(DECI_CYC - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pre_q <= '0;
    else pre_q <= tick ? '0 : pre_q + 32'h1;
  end

  // apb decode
  assign acc   = psel && penable;
  assign zhit  = (paddr[11:5] == 7'h01 || paddr[11:5] == 7'h02) &&
                 paddr[4:2] < 3'h6 && paddr[1:0] == 2'h0;
  assign fhit  = paddr[11:5] == 7'h03 && paddr[4:2] < 3'h5 && paddr[1:0] == 2'h0;
  assign chit  = paddr == `FTA_A_CTRL || paddr == `FTA_A_CLEAR ||
                 paddr == `FTA_A_STATUS || paddr == `FTA_A_DISP ||
                 paddr == `FTA_A_UNLOCK;
  assign ok_wr = (zhit && mode_q == FTA_CFG) ||
                 (fhit && mode_q == FTA_CFG && unlock_q);
  assign wv    = (|pwdata[31:7]) ? 7'h7f : pwdata[6:0];
  assign clr_wr = acc && pwrite && paddr == `FTA_A_CLEAR && pwdata[0];
  assign pready = 1'b1;

  always_comb begin
    rdata = '0;
    rerr  = 1'b0;
    if (zhit) rdata[6:0] = zp_q[paddr[6]][paddr[4:2]];
    else if (fhit) rdata[6:0] = fp_q[paddr[4:2]];
    else if (paddr == `FTA_A_CTRL)
      rdata[7:0] = {fview_q, psel_q, ssel_q, zsel_q, mode_q};
    else if (paddr == `FTA_A_STATUS)
      rdata[12:0] = {unlock_q, manual_q, supervision_relay, kwin_on, cwin_on,
                     alm_clb, alm_cut, relay_on};
    else if (paddr == `FTA_A_DISP) rdata[7:0] = peak_q;
    else if (!chit) rerr = 1'b1;
    if (pwrite && (zhit || fhit) && !ok_wr) rerr = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= pwrite ? '0 : rdata;
      pslverr <= rerr;
    end
  end

  // control and unlock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q   <= FTA_MON;
      zsel_q   <= 1'b0;
      ssel_q   <= 1'b0;
      psel_q   <= 3'h0;
      fview_q  <= 1'b0;
      unlock_q <= 1'b0;
    end else if (acc && pwrite) begin
      if (paddr == `FTA_A_CTRL) begin
        mode_q  <= (pwdata[1:0] == 2'h2) ? mode_q : fta_mode_e'(pwdata[1:0]);
        zsel_q  <= pwdata[2];
        ssel_q  <= pwdata[3];
        psel_q  <= pwdata[6:4];
        fview_q <= pwdata[7];
        if (pwdata[1:0] != 2'h1) unlock_q <= 1'b0;
      end else if (paddr == `FTA_A_UNLOCK) begin
        unlock_q <= pwdata[15:0] == CIPHER;
      end
    end
  end

  // parameter store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int z = 0; z < 2; z++)
        for (int k = 0; k < `FTA_ZP_N; k++) zp_q[z][k] <= zdef(k);
      for (int k = 0; k < `FTA_FP_N; k++) fp_q[k] <= fdef(k);
    end else if (acc && pwrite && ok_wr) begin
      if (zhit) begin
        case (paddr[4:2])
          3'h0: zp_q[paddr[6]][0] <= clampv(wv, `FTA_WIN_MIN, `FTA_WIN_MAX);
          3'h1: zp_q[paddr[6]][1] <= clampv(wv, zp_q[paddr[6]][5], `FTA_WIN_MAX);
          3'h2: zp_q[paddr[6]][2] <= clampv(wv, `FTA_THR_MIN, `FTA_THR_MAX);
          3'h3: zp_q[paddr[6]][3] <= clampv(wv, `FTA_THR_MIN, `FTA_THR_MAX);
          3'h4: zp_q[paddr[6]][4] <= clampv(wv, `FTA_CCNT_MIN, `FTA_CCNT_MAX);
          default: zp_q[paddr[6]][5] <= clampv(wv, `FTA_CTIM_MIN, zp_q[paddr[6]][1]);
        endcase
      end else begin
        case (paddr[4:2])
          3'h0: fp_q[0] <= clampv(wv, `FTA_RLY_MIN, `FTA_RLY_MAX);
          3'h4: fp_q[4] <= clampv(wv, 7'h00, `FTA_CMOD_MAX);
          default: fp_q[paddr[4:2]] <= clampv(wv, 7'h00, `FTA_FP_MAX);
        endcase
      end
    end
  end

  assign detect   = mode_q == FTA_MON;
  assign amb_diff = (am_s2[0] > am_s2[1]) ? am_s2[0] - am_s2[1] : am_s2[1] - am_s2[0];
  assign similar  = amb_diff <= AMB_TOL;
  assign comp_on  = !fp_q[4][0] || similar;

  for (genvar z = 0; z < 2; z++) begin : g_zone
    logic [15:0] amb_t, cbase, kbase, cut_lvl, clb_lvl, e10;
    logic        cut_hi, clb_hi, cut_hi_q, clb_hi_q, cut_alm, clb_alm, kstep;
    logic [15:0] cwin_q, kwin_q;
    logic [3:0]  ccnt_q;
    logic [9:0]  kacc_q, rly_q;
    logic        acut_q, aclb_q;

    assign amb_t   = comp_on ? 16'(am_s2[z] * fp_q[3]) : 16'h0000;
    assign cbase   = 16'(zp_q[z][2] * THR_SCALE);
    assign kbase   = 16'(zp_q[z][3] * THR_SCALE);
    assign cut_lvl = 16'(cbase * 16'd10) + amb_t + 16'(cbase * fp_q[2]);
    assign clb_lvl = 16'(kbase * 16'd10) + amb_t;
    assign e10     = 16'(en_s2[z] * 16'd10);
    assign cut_hi  = e10 > cut_lvl;
    assign clb_hi  = e10 > clb_lvl;
    assign cut_ev[z] = detect && cut_hi && !cut_hi_q;
    assign clb_ev[z] = detect && clb_hi && !clb_hi_q;
    assign kstep   = detect && tick && clb_hi;
    assign cut_alm = cut_ev[z] && (7'(ccnt_q) + 7'h01 >= zp_q[z][4]);
    assign clb_alm = kstep && (kacc_q + 10'h001 >= 10'(zp_q[z][5] * 10'd10));

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cut_hi_q <= 1'b0;
        clb_hi_q <= 1'b0;
      end else begin
        cut_hi_q <= cut_hi;
        clb_hi_q <= clb_hi;
      end
    end

    // cut window and count
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cwin_q <= '0;
        ccnt_q <= '0;
      end else if (!detect || cut_alm) begin
        cwin_q <= '0;
        ccnt_q <= '0;
      end else if (cut_ev[z]) begin
        if (cwin_q == '0) begin
          cwin_q <= 16'(zp_q[z][0] * 16'd10);
          ccnt_q <= 4'h1;
        end else begin
          cwin_q <= cwin_q + 16'(zp_q[z][0] * fp_q[1]);
          ccnt_q <= ccnt_q + 4'h1;
        end
      end else if (tick && cwin_q != '0) begin
        cwin_q <= cwin_q - 16'h1;
        if (cwin_q == 16'h1) ccnt_q <= '0;
      end
    end

    // climb window and accumulated time
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        kwin_q <= '0;
        kacc_q <= '0;
      end else if (!detect || clb_alm) begin
        kwin_q <= '0;
        kacc_q <= '0;
      end else if (kstep && kwin_q == '0) begin
        kwin_q <= 16'(zp_q[z][1] * 16'd10);
        kacc_q <= 10'h001;
      end else begin
        if (kstep) kacc_q <= kacc_q + 10'h001;
        if (tick && kwin_q != '0) kwin_q <= kwin_q - 16'h1;
        if (tick && kwin_q == 16'h1 && !kstep) kacc_q <= '0;
      end
    end

    // relay hold and alarm cause
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rly_q  <= '0;
        acut_q <= 1'b0;
        aclb_q <= 1'b0;
      end else if (cut_alm || clb_alm) begin
        rly_q  <= 10'(fp_q[0] * 10'd10);
        acut_q <= acut_q || cut_alm;
        aclb_q <= aclb_q || clb_alm;
      end else if (tick && rly_q != '0) begin
        rly_q <= rly_q - 10'h001;
        if (rly_q == 10'h001) begin
          acut_q <= 1'b0;
          aclb_q <= 1'b0;
        end
      end
    end

    assign relay_on[z] = rly_q != '0;
    assign alm_cut[z]  = acut_q;
    assign alm_clb[z]  = aclb_q;
    assign cwin_on[z]  = cwin_q != '0;
    assign kwin_on[z]  = kwin_q != '0;
    assign rem_cut[z]  = zp_q[z][4] - 7'(ccnt_q);
    assign rem_clb[z]  = zp_q[z][5] - 7'(kacc_q / 10'd10);
  end

  // supervision relay minimum on-time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sup_tmr_q <= '0;
    else if (sup_s2) sup_tmr_q <= 10'(fp_q[0] * 10'd10);
    else if (tick && sup_tmr_q != '0) sup_tmr_q <= sup_tmr_q - 10'h001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_relay       <= 2'b00;
      supervision_relay <= 1'b0;
    end else begin
      alarm_relay       <= relay_on;
      supervision_relay <= sup_s2 || sup_tmr_q != '0;
    end
  end

  // level mode peak capture and clearing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      manual_q <= 1'b0;
      peak_q   <= '0;
      hold_q   <= '0;
    end else if (mode_q != FTA_LVL) begin
      manual_q <= 1'b0;
      peak_q   <= '0;
      hold_q   <= '0;
    end else if (clr_wr) begin
      manual_q <= 1'b1;
      peak_q   <= '0;
      hold_q   <= '0;
    end else if (en_s2[zsel_q] > peak_q) begin
      peak_q <= en_s2[zsel_q];
      hold_q <= HOLD_D;
    end else if (!manual_q && tick && hold_q != '0) begin
      hold_q <= hold_q - 5'h01;
      if (hold_q == 5'h01) peak_q <= '0;
    end
  end

  // threshold indicator pulse for the viewed zone and scenario
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) thr_q <= 1'b0;
    else if (ssel_q ? clb_ev[zsel_q] : cut_ev[zsel_q]) thr_q <= 1'b1;
    else if (tick) thr_q <= 1'b0;
  end

  always_comb begin
    led_d = '0;
    disp_d = '0;
    led_d.monitor     = mode_q != FTA_CFG;
    led_d.configure   = mode_q == FTA_CFG;
    led_d.level       = mode_q == FTA_LVL;
    led_d.supervision = supervision_relay;
    led_d.zone1       = !zsel_q;
    led_d.zone2       = zsel_q;
    unique case (mode_q)
      FTA_MON: begin
        led_d.cut       = !ssel_q;
        led_d.climb     = ssel_q;
        led_d.window    = ssel_q ? kwin_on[zsel_q] : cwin_on[zsel_q];
        led_d.threshold = thr_q;
        disp_d          = ssel_q ? rem_clb[zsel_q] : rem_cut[zsel_q];
        if (|relay_on) begin
          led_d.alarm = 1'b1;
          led_d.zone1 = relay_on[0];
          led_d.zone2 = relay_on[1];
          led_d.cut   = |alm_cut;
          led_d.climb = |alm_clb;
        end
      end
      FTA_CFG: begin
        if (fview_q) begin
          led_d.zone1 = 1'b1;
          led_d.zone2 = 1'b1;
          disp_d      = (psel_q < 3'h5) ? fp_q[psel_q] : 7'h00;
        end else begin
          led_d.cut   = psel_q < 3'h3 && psel_q != 3'h1 ? !ssel_q : psel_q == 3'h4;
          led_d.climb = psel_q < 3'h4 && !led_d.cut;
          led_d.window    = psel_q < 3'h2;
          led_d.threshold = psel_q == 3'h2 || psel_q == 3'h3;
          disp_d      = (psel_q < 3'h6) ? zp_q[zsel_q][psel_q] : 7'h00;
        end
      end
      FTA_LVL: begin
        disp_d = (peak_q > `FTA_DISP_MAX) ? 7'(`FTA_DISP_MAX) : peak_q[6:0];
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      leds    <= '0;
      display <= '0;
    end else begin
      leds    <= led_d;
      display <= disp_d;
    end
  end
endmodule

// ### tb/fta_top_asserts.sv
`timescale 1ns/1ps
module fta_top_asserts import fta_pkg::*; (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [1:0]  alarm_relay,
  input wire logic        supervision_relay,
  input wire fta_led_s    leds,
  input wire logic [6:0]  display
);
  logic ctl_wr;
  logic clr_wr;
  assign ctl_wr = psel && penable && pwrite && (paddr == 12'h000);
  assign clr_wr = psel && penable && pwrite && (paddr == 12'h004) && pwdata[0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_cfg_no_alarm: assert property (leds.configure [*3] |->
    !$rose(alarm_relay[0]) && !$rose(alarm_relay[1])) else $error("alarm raised in configure");
  a_lvl_no_alarm: assert property (leds.level [*3] |->
    !$rose(alarm_relay[0]) && !$rose(alarm_relay[1])) else $error("alarm raised in level");
  a_cut_leds: assert property ($rose(alarm_relay[0]) && leds.monitor |->
    ##[0:3] (leds.alarm && leds.zone1)) else $error("alarm indicators missing");
  a_relay_hold: assert property ($rose(alarm_relay[0]) |=>
    alarm_relay[0] [*8]) else $error("alarm relay dropped early");
  a_sup_hold: assert property ($rose(supervision_relay) |=>
    supervision_relay [*8]) else $error("supervision relay dropped early");
  a_common_zones: assert property (ctl_wr && pwdata[7] && pwdata[1:0] == 2'b01 |->
    ##[1:3] (leds.zone1 && leds.zone2)) else $error("common view lacks both zones");
  a_cfg_entry: assert property (ctl_wr && pwdata[1:0] == 2'b01 |->
    ##[1:3] leds.configure) else $error("configure not entered");
  a_lvl_entry: assert property (ctl_wr && pwdata[1:0] == 2'b11 |->
    ##[1:3] leds.level) else $error("level not entered");
  a_lvl_clear: assert property (leds.level && clr_wr |->
    ##[1:4] display == 7'h00) else $error("clear left reading");
  a_disp_range: assert property (display <= 7'h63) else $error("display above 99");
endmodule

bind fta_top fta_top_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .alarm_relay(alarm_relay),
  .supervision_relay(supervision_relay), .leds(leds), .display(display)
);

// ### tb/fta_front_model.sv
`timescale 1ns/1ps
module fta_front_model (
  input  wire logic            pclk,
  output logic      [1:0][7:0] sensor_energy,
  output logic      [1:0][7:0] ambient_level,
  output logic                 supervision_in
);
  initial begin
    sensor_energy  = '0;
    ambient_level  = '0;
    supervision_in = 1'b0;
  end
  // quiet gap after each burst so the next one is a fresh crossing
  task automatic burst(input int z, input logic [7:0] amp, input logic [7:0] amb,
                       input logic sup);
    @(posedge pclk);
    sensor_energy[z] <= amp;
    ambient_level    <= {amb, amb};
    supervision_in   <= sup;
    repeat (20) @(posedge pclk);
    sensor_energy[z] <= 8'h00;
    supervision_in   <= 1'b0;
    repeat (20) @(posedge pclk);
  endtask
endmodule

// ### tb/fta_top_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
  $display("mismatch at %0t: got %0h exp %0h", $time, (a), (b)); end end
module fta_top_tb_top import fta_pkg::*;;
  localparam logic [15:0] KEY = 16'h3c96;  // arbitrary value
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic            supervision_in, supervision_relay;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, rd;
  logic [1:0][7:0] sensor_energy, ambient_level;
  logic [1:0]      alarm_relay;
  fta_led_s        leds, l;
  logic [6:0]      display;
  int              n_mismatch, comparisons, n, th;

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  fta_top #(.SEC_CYC(100), .CIPHER(KEY)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sensor_energy(sensor_energy), .ambient_level(ambient_level),
    .supervision_in(supervision_in), .alarm_relay(alarm_relay),
    .supervision_relay(supervision_relay), .leds(leds), .display(display)
  );
  fta_front_model u_fe (
    .pclk(pclk), .sensor_energy(sensor_energy), .ambient_level(ambient_level),
    .supervision_in(supervision_in)
  );

  task automatic stop_test();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 64);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (t >= 64) begin
      n_mismatch++;
      stop_test();
    end
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    `CHK(rd, exp)
  endtask

  // one burst while counting relay-high cycles over a fixed span
  task automatic burst_count(input logic [7:0] amp, input logic sup);
    n = 0;
    th = 0;
    fork
      u_fe.burst(0, amp, 8'h00, sup);
      repeat (400) begin
        @(posedge pclk);
        if ((sup ? supervision_relay : alarm_relay[0]) === 1'b1) begin
          n++;
          l = leds;
        end
        if (leds.threshold === 1'b1) th++;
      end
    join
  endtask

  task automatic t_config();
    apb(1'b1, 12'h000, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK(leds.configure, 1'b1)
    rdchk(12'h020, 32'h1e);
    rdchk(12'h024, 32'h14);
    rdchk(12'h028, 32'h0a);
    rdchk(12'h02c, 32'h0a);
    rdchk(12'h030, 32'h04);
    rdchk(12'h034, 32'h02);
    apb(1'b1, 12'h020, 32'h0);
    rdchk(12'h020, 32'h01);
    apb(1'b1, 12'h020, 32'hc8);
    rdchk(12'h020, 32'h63);
    apb(1'b1, 12'h024, 32'h1);
    rdchk(12'h024, 32'h02);
    apb(1'b1, 12'h020, 32'h1e);
    burst_count(8'hc8, 1'b0);
    `CHK(n, 0)
    `CHK(th, 0)
    apb(1'b1, 12'h060, 32'h5);
    `CHK(err, 1'b1)
    apb(1'b1, 12'h010, {16'h0, KEY});
    rdchk(12'h060, 32'h02);
    rdchk(12'h064, 32'h02);
    rdchk(12'h068, 32'h03);
    rdchk(12'h06c, 32'h0a);
    rdchk(12'h070, 32'h00);
    apb(1'b1, 12'h070, 32'h5);
    rdchk(12'h070, 32'h01);
    apb(1'b1, 12'h070, 32'h0);
    apb(1'b1, 12'h000, 32'h81);
    repeat (2) @(posedge pclk);
    `CHK({leds.zone1, leds.zone2}, 2'b11)
    apb(1'b0, 12'h100, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    $display("test config done");
  endtask

  task automatic t_cut();
    apb(1'b1, 12'h000, 32'h0);
    repeat (3) @(posedge pclk);
    `CHK(display, 7'h04)
    u_fe.burst(0, 8'h00, 8'h64, 1'b0);
    u_fe.burst(0, 8'hc8, 8'h64, 1'b0);
    `CHK(display, 7'h04)
    repeat (3) u_fe.burst(0, 8'hc8, 8'h00, 1'b0);
    `CHK(display, 7'h01)
    `CHK(leds.window, 1'b1)
    burst_count(8'hc8, 1'b0);
    `CHK((n >= 185 && n <= 230), 1'b1)
    `CHK((th > 0), 1'b1)
    `CHK(leds.window, 1'b0)
    `CHK({l.alarm, l.cut, l.zone1, l.zone2}, 4'b1110)
    burst_count(8'h00, 1'b1);
    `CHK((n >= 185 && n <= 230), 1'b1)
    $display("test cut done");
  endtask

  task automatic t_level();
    apb(1'b1, 12'h000, 32'h3);
    repeat (2) @(posedge pclk);
    `CHK(leds.level, 1'b1)
    burst_count(8'hc8, 1'b0);
    `CHK(n, 0)
    `CHK(th, 0)
    `CHK(display, 7'h00)
    u_fe.burst(0, 8'hc8, 8'h00, 1'b0);
    `CHK((display === 7'h00), 1'b0)
    apb(1'b1, 12'h004, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK(display, 7'h00)
    u_fe.burst(0, 8'hc8, 8'h00, 1'b0);
    repeat (300) @(posedge pclk);
    `CHK((display === 7'h00), 1'b0)
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h000, 32'h3);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rd[11], 1'b0)
    $display("test level done");
  endtask

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    n_mismatch  = 0;
    comparisons = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_config();
    t_cut();
    t_level();
    stop_test();
  end
endmodule
